/* File: verilog/ssx_exec.sv */
// Execution unit for decimal subtract, set on condition, halt and binary subtract
// Notes on behaviour
// - Decimal byte subtract with sticky borrow
// - Mode bit picks registers or predecrement memory
// - Two fields name destination and source registers
// - Sticky borrow copies the borrow flag
// - Zero flag only cleared on nonzero
// - Borrow flag follows decimal borrow
// - Set byte writes all ones or zeros
// - Condition codes zero through seven
// - Condition codes eight through fifteen
// - Set byte target must be data alterable
// - Privileged halt loads status, advances counter
// - Halt ends on trace, interrupt, reset
// - Trace at halt start raises trace exception
// - Only higher-priority interrupt ends halt
// - Reset always starts reset exception
// - Binary subtract byte word or long
// - Opmode picks size and destination side
// - Binary subtract sets all flags
// - Memory destination must be memory alterable
// - Byte source not address register
`timescale 1ns/1ps
`default_nettype none

module ssx_exec
	import ssx_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire ssx_apb_req_t apb_req,
	output ssx_apb_rsp_t apb_rsp,
	input wire logic [2:0] irq_level,
	output logic core_halted,
	output ssx_exc_t exc_code
);

	////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		ssx_state_t state;
		logic [15:0] sr;
		logic [15:0] opcode;
		logic [15:0] ext;
		logic [31:0] src;
		logic [31:0] dst;
		logic [31:0] pc;
		logic [31:0] result;
		ssx_exc_t exc;
		logic trace_pend;
		logic mem_mode;
		logic [2:0] dst_sel;
		logic [2:0] src_sel;
		logic ea_dst;
		logic [1:0] size;
		logic [31:0] prdata;
	} ssx_st_t;

	ssx_st_t st_reg;
	ssx_st_t st_next;

	////////////////////////////////////////////////////////////////////////
	// Datapath functions
	function automatic logic [8:0] bcd_sub(input logic [7:0] d, input logic [7:0] s,
		input logic x);
		logic [4:0] lo;
		logic [4:0] hi;
		logic lo_b;
		lo = {1'b0, d[3:0]} - {1'b0, s[3:0]} - {4'h0, x};
		lo_b = lo[4];
		if (lo_b) begin
			lo = lo - {1'b0, SSX_BCD_FIX};
		end
		hi = {1'b0, d[7:4]} - {1'b0, s[7:4]} - {4'h0, lo_b};
		if (hi[4]) begin
			hi = hi - {1'b0, SSX_BCD_FIX};
		end
		return {hi[4], hi[3:0], lo[3:0]};
	endfunction

	function automatic logic cond_true(input logic [3:0] cc, input logic [15:0] sr);
		logic c;
		logic v;
		logic z;
		logic n;
		c = sr[SSX_SR_C];
		v = sr[SSX_SR_V];
		z = sr[SSX_SR_Z];
		n = sr[SSX_SR_N];
		unique case (cc)
			SSX_CC_ALWAYS: return 1'b1;
			SSX_CC_NEVER: return 1'b0;
			SSX_CC_HIGHER: return ~c & ~z;
			SSX_CC_LOWER_SAME: return c | z;
			SSX_CC_NO_BORROW: return ~c;
			SSX_CC_BORROW: return c;
			SSX_CC_DIFFER: return ~z;
			SSX_CC_SAME: return z;
			SSX_CC_NO_SPILL: return ~v;
			SSX_CC_SPILL: return v;
			SSX_CC_NONNEG: return ~n;
			SSX_CC_NEGATIVE: return n;
			SSX_CC_SGE: return ~(n ^ v);
			SSX_CC_SLT: return n ^ v;
			SSX_CC_SGT: return ~(n ^ v) & ~z;
			SSX_CC_SLE: return (n ^ v) | z;
		endcase
	endfunction

	// Returns {borrow, overflow, negative, zero, result}
	function automatic logic [35:0] bin_sub(input logic [31:0] d, input logic [31:0] s,
		input logic [1:0] sz);
		logic [32:0] df;
		logic c;
		logic v;
		logic n;
		logic z;
		logic [31:0] r;
		df = 33'h0;
		c = 1'b0;
		v = 1'b0;
		n = 1'b0;
		z = 1'b0;
		r = d;
		if (sz == SSX_SIZE_BYTE) begin
			df = {25'h0, d[7:0]} - {25'h0, s[7:0]};
			r = {d[31:8], df[7:0]};
			c = df[8];
			n = df[7];
			v = (d[7] ^ s[7]) & (df[7] ^ d[7]);
			z = (df[7:0] == 8'h00);
		end else if (sz == SSX_SIZE_WORD) begin
			df = {17'h0, d[15:0]} - {17'h0, s[15:0]};
			r = {d[31:16], df[15:0]};
			c = df[16];
			n = df[15];
			v = (d[15] ^ s[15]) & (df[15] ^ d[15]);
			z = (df[15:0] == 16'h0000);
		end else begin
			df = {1'b0, d} - {1'b0, s};
			r = df[31:0];
			c = df[32];
			n = df[31];
			v = (d[31] ^ s[31]) & (df[31] ^ d[31]);
			z = (df[31:0] == 32'h0);
		end
		return {c, v, n, z, r};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Decode
	logic [2:0] ea_mode;
	logic [2:0] ea_reg;
	logic [2:0] opmode;
	logic is_bcd;
	logic is_scc;
	logic is_sub;
	logic is_halt;
	logic data_alt;
	logic mem_alt;
	logic sub_src_ok;
	logic [8:0] bcd_out;
	logic [35:0] sub_out;
	logic cond_hit;

	assign ea_mode = st_reg.opcode[5:3];
	assign ea_reg = st_reg.opcode[2:0];
	assign opmode = st_reg.opcode[8:6];
	assign is_bcd = (st_reg.opcode[15:12] == SSX_OP_BCD_TOP) &&
		(st_reg.opcode[8:4] == SSX_OP_BCD_MID);
	assign is_scc = (st_reg.opcode[15:12] == SSX_OP_SCC_TOP) &&
		(st_reg.opcode[7:6] == 2'h3);
	assign is_sub = (st_reg.opcode[15:12] == SSX_OP_SUB_TOP) &&
		(opmode[1:0] != 2'h3);
	assign is_halt = (st_reg.opcode == SSX_OP_HALT);
	assign mem_alt = (ea_mode != SSX_MODE_DREG) && (ea_mode != SSX_MODE_AREG) &&
		((ea_mode != SSX_MODE_EXT) || (ea_reg <= SSX_EXT_ABS_LONG));
	assign data_alt = mem_alt || (ea_mode == SSX_MODE_DREG);
	assign sub_src_ok = !((opmode[1:0] == SSX_SIZE_BYTE) && (ea_mode == SSX_MODE_AREG)) &&
		((ea_mode != SSX_MODE_EXT) || (ea_reg <= SSX_EXT_IMM));
	assign bcd_out = bcd_sub(st_reg.dst[7:0], st_reg.src[7:0], st_reg.sr[SSX_SR_X]);
	assign sub_out = bin_sub(st_reg.dst, st_reg.src, opmode[1:0]);
	assign cond_hit = cond_true(st_reg.opcode[11:8], st_reg.sr);

	////////////////////////////////////////////////////////////////////////
	// Operand fields and accepted forms
	logic [2:0] dst_reg_field;
	logic [2:0] src_reg_field;
	logic operand_mode_select;
	logic scc_ok;
	logic sub_ok;
	logic [7:0] scc_byte;
	logic sub_borrow;
	logic sub_spill;
	logic sub_neg;
	logic sub_zero;
	logic [31:0] sub_res;

	assign dst_reg_field = st_reg.opcode[11:9];
	assign src_reg_field = st_reg.opcode[2:0];
	assign operand_mode_select = st_reg.opcode[3];
	assign scc_ok = is_scc && data_alt;
	assign sub_ok = is_sub && (opmode[2] ? mem_alt : sub_src_ok);
	assign scc_byte = {8{cond_hit}};
	assign {sub_borrow, sub_spill, sub_neg, sub_zero, sub_res} = sub_out;

	////////////////////////////////////////////////////////////////////////
	// Halt control
	logic irq_wake;
	logic trace_on;
	logic [31:0] pc_after_halt;

	assign irq_wake = irq_level > st_reg.sr[SSX_SR_MASK_LO +: 3];
	assign trace_on = st_reg.sr[SSX_SR_T0] & ~st_reg.sr[SSX_SR_T1];
	assign pc_after_halt = st_reg.pc + SSX_PC_STEP_HALT;

	////////////////////////////////////////////////////////////////////////
	// Register read mux
	logic [31:0] rd_data;
	logic addr_ok;

	always_comb begin
		rd_data = 32'h0;
		addr_ok = 1'b1;
		unique case (apb_req.paddr)
			SSX_ADDR_CTRL: rd_data = 32'h0;
			SSX_ADDR_OPCODE: rd_data = {16'h0, st_reg.opcode};
			SSX_ADDR_EXT: rd_data = {16'h0, st_reg.ext};
			SSX_ADDR_SRC: rd_data = st_reg.src;
			SSX_ADDR_DST: rd_data = st_reg.dst;
			SSX_ADDR_STATUS: rd_data = {16'h0, st_reg.sr};
			SSX_ADDR_RESULT: rd_data = st_reg.result;
			SSX_ADDR_PC: rd_data = st_reg.pc;
			SSX_ADDR_INFO: begin
				rd_data[SSX_INFO_HALT] = (st_reg.state == SSX_HALT);
				rd_data[SSX_INFO_EXC_LO +: 3] = st_reg.exc;
				rd_data[SSX_INFO_MEM] = st_reg.mem_mode;
				rd_data[SSX_INFO_DST_LO +: 3] = st_reg.dst_sel;
				rd_data[SSX_INFO_SRC_LO +: 3] = st_reg.src_sel;
				rd_data[SSX_INFO_EA_DST] = st_reg.ea_dst;
				rd_data[SSX_INFO_SIZE_LO +: 2] = st_reg.size;
				rd_data[SSX_INFO_BUSY] = (st_reg.state == SSX_EXEC);
			end
			default: addr_ok = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	logic setup_cyc;
	logic acc_cyc;
	logic wr_en;
	logic start_ok;

	assign setup_cyc = apb_req.psel && !apb_req.penable;
	assign acc_cyc = apb_req.psel && apb_req.penable;
	assign wr_en = acc_cyc && apb_req.pwrite;
	assign start_ok = apb_req.pwdata[SSX_CTRL_START] && (st_reg.state == SSX_IDLE);

	always_comb begin
		st_next = st_reg;
		if (setup_cyc) begin
			st_next.prdata = rd_data;
		end
		if (wr_en) begin
			unique case (apb_req.paddr)
				SSX_ADDR_CTRL: begin
					if (start_ok) begin
						st_next.state = SSX_EXEC;
						st_next.exc = SSX_EXC_NONE;
					end
				end
				SSX_ADDR_OPCODE: st_next.opcode = apb_req.pwdata[15:0];
				SSX_ADDR_EXT: st_next.ext = apb_req.pwdata[15:0];
				SSX_ADDR_SRC: st_next.src = apb_req.pwdata;
				SSX_ADDR_DST: st_next.dst = apb_req.pwdata;
				SSX_ADDR_STATUS: st_next.sr = apb_req.pwdata[15:0];
				SSX_ADDR_PC: st_next.pc = apb_req.pwdata;
				default: begin
				end
			endcase
		end
		unique case (st_reg.state)
			SSX_IDLE: begin
			end
			SSX_EXEC: begin
				st_next.state = SSX_IDLE;
				st_next.mem_mode = 1'b0;
				st_next.ea_dst = 1'b0;
				st_next.size = SSX_SIZE_BYTE;
				if (is_bcd) begin
					st_next.result = {st_reg.dst[31:8], bcd_out[7:0]};
					st_next.mem_mode = operand_mode_select;
					st_next.ea_dst = operand_mode_select;
					st_next.dst_sel = dst_reg_field;
					st_next.src_sel = src_reg_field;
					st_next.sr[SSX_SR_C] = bcd_out[8];
					st_next.sr[SSX_SR_X] = bcd_out[8];
					if (bcd_out[7:0] != 8'h00) begin
						st_next.sr[SSX_SR_Z] = 1'b0;
					end
				end else if (scc_ok) begin
					st_next.result = {st_reg.dst[31:8], scc_byte};
					st_next.dst_sel = ea_reg;
					st_next.src_sel = ea_mode;
					st_next.ea_dst = (ea_mode != SSX_MODE_DREG);
				end else if (sub_ok) begin
					st_next.result = sub_res;
					st_next.size = opmode[1:0];
					st_next.ea_dst = opmode[2];
					st_next.dst_sel = dst_reg_field;
					st_next.src_sel = ea_reg;
					st_next.sr[SSX_SR_C] = sub_borrow;
					st_next.sr[SSX_SR_X] = sub_borrow;
					st_next.sr[SSX_SR_V] = sub_spill;
					st_next.sr[SSX_SR_N] = sub_neg;
					st_next.sr[SSX_SR_Z] = sub_zero;
				end else if (is_halt) begin
					if (st_reg.sr[SSX_SR_S]) begin
						st_next.sr = st_reg.ext;
						st_next.pc = pc_after_halt;
						st_next.trace_pend = trace_on;
						st_next.state = SSX_HALT;
					end else begin
						st_next.exc = SSX_EXC_PRIV;
					end
				end else begin
					st_next.exc = SSX_EXC_ILLEGAL;
				end
			end
			SSX_HALT: begin
				if (st_reg.trace_pend) begin
					st_next.exc = SSX_EXC_TRACE;
					st_next.trace_pend = 1'b0;
					st_next.state = SSX_IDLE;
				end else if (irq_wake) begin
					st_next.exc = SSX_EXC_IRQ;
					st_next.state = SSX_IDLE;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.state <= SSX_IDLE;
			st_reg.exc <= SSX_EXC_RESET;
			st_reg.sr <= SSX_SR_RESET;
			st_reg.pc <= SSX_PC_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	always_comb begin
		apb_rsp = '0;
		apb_rsp.prdata = st_reg.prdata;
		apb_rsp.pready = 1'b1;
		apb_rsp.pslverr = acc_cyc && !addr_ok;
	end
	assign core_halted = (st_reg.state == SSX_HALT);
	assign exc_code = st_reg.exc;

endmodule

`default_nettype wire

/* File: verilog/ssx_pkg.sv */
// Package for the subtract, set-on-condition and halt execution block
package ssx_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] SSX_ADDR_CTRL = 8'h00;
	localparam logic [7:0] SSX_ADDR_OPCODE = 8'h04;
	localparam logic [7:0] SSX_ADDR_EXT = 8'h08;
	localparam logic [7:0] SSX_ADDR_SRC = 8'h0c;
	localparam logic [7:0] SSX_ADDR_DST = 8'h10;
	localparam logic [7:0] SSX_ADDR_STATUS = 8'h14;
	localparam logic [7:0] SSX_ADDR_RESULT = 8'h18;
	localparam logic [7:0] SSX_ADDR_INFO = 8'h1c;
	localparam logic [7:0] SSX_ADDR_PC = 8'h20;

	////////////////////////////////////////////////////////////////////////
	// Status word fields and reset values
	localparam int unsigned SSX_SR_C = 0;
	localparam int unsigned SSX_SR_V = 1;
	localparam int unsigned SSX_SR_Z = 2;
	localparam int unsigned SSX_SR_N = 3;
	localparam int unsigned SSX_SR_X = 4;
	localparam int unsigned SSX_SR_MASK_LO = 8;
	localparam int unsigned SSX_SR_S = 13;
	localparam int unsigned SSX_SR_T0 = 14;
	localparam int unsigned SSX_SR_T1 = 15;
	localparam logic [15:0] SSX_SR_RESET = 16'h2700;
	localparam logic [31:0] SSX_PC_RESET = 32'h0000_0000;
	localparam logic [31:0] SSX_PC_STEP_HALT = 32'h0000_0004;
	localparam int unsigned SSX_CTRL_START = 0;

	////////////////////////////////////////////////////////////////////////
	// Info register fields
	localparam int unsigned SSX_INFO_HALT = 0;
	localparam int unsigned SSX_INFO_EXC_LO = 1;
	localparam int unsigned SSX_INFO_MEM = 4;
	localparam int unsigned SSX_INFO_DST_LO = 5;
	localparam int unsigned SSX_INFO_SRC_LO = 8;
	localparam int unsigned SSX_INFO_EA_DST = 11;
	localparam int unsigned SSX_INFO_SIZE_LO = 12;
	localparam int unsigned SSX_INFO_BUSY = 14;

	////////////////////////////////////////////////////////////////////////
	// Opcodes, sizes, addressing modes
	localparam logic [15:0] SSX_OP_HALT = 16'h4e72;
	localparam logic [3:0] SSX_OP_SCC_TOP = 4'h5;
	localparam logic [3:0] SSX_OP_BCD_TOP = 4'h8;
	localparam logic [3:0] SSX_OP_SUB_TOP = 4'hd;
	localparam logic [4:0] SSX_OP_BCD_MID = 5'h10;
	localparam logic [1:0] SSX_SIZE_BYTE = 2'h0;
	localparam logic [1:0] SSX_SIZE_WORD = 2'h1;
	localparam logic [1:0] SSX_SIZE_LONG = 2'h2;
	localparam logic [2:0] SSX_MODE_DREG = 3'h0;
	localparam logic [2:0] SSX_MODE_AREG = 3'h1;
	localparam logic [2:0] SSX_MODE_EXT = 3'h7;
	localparam logic [2:0] SSX_EXT_ABS_LONG = 3'h1;
	localparam logic [2:0] SSX_EXT_IMM = 3'h4;

	////////////////////////////////////////////////////////////////////////
	// Condition codes
	localparam logic [3:0] SSX_CC_ALWAYS = 4'h0;
	localparam logic [3:0] SSX_CC_NEVER = 4'h1;
	localparam logic [3:0] SSX_CC_HIGHER = 4'h2;
	localparam logic [3:0] SSX_CC_LOWER_SAME = 4'h3;
	localparam logic [3:0] SSX_CC_NO_BORROW = 4'h4;
	localparam logic [3:0] SSX_CC_BORROW = 4'h5;
	localparam logic [3:0] SSX_CC_DIFFER = 4'h6;
	localparam logic [3:0] SSX_CC_SAME = 4'h7;
	localparam logic [3:0] SSX_CC_NO_SPILL = 4'h8;
	localparam logic [3:0] SSX_CC_SPILL = 4'h9;
	localparam logic [3:0] SSX_CC_NONNEG = 4'ha;
	localparam logic [3:0] SSX_CC_NEGATIVE = 4'hb;
	localparam logic [3:0] SSX_CC_SGE = 4'hc;
	localparam logic [3:0] SSX_CC_SLT = 4'hd;
	localparam logic [3:0] SSX_CC_SGT = 4'he;
	localparam logic [3:0] SSX_CC_SLE = 4'hf;
	localparam logic [3:0] SSX_BCD_FIX = 4'h6;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0] {SSX_IDLE, SSX_EXEC, SSX_HALT} ssx_state_t;
	typedef enum logic [2:0] {
		SSX_EXC_NONE, SSX_EXC_RESET, SSX_EXC_TRACE, SSX_EXC_IRQ, SSX_EXC_PRIV, SSX_EXC_ILLEGAL
	} ssx_exc_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} ssx_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ssx_apb_rsp_t;

endpackage

/* File: dv/ssx_exec_props.sv */
// Port checker for the execution block
`timescale 1ns/1ps
`default_nettype none
module ssx_exec_props
	import ssx_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire ssx_apb_req_t apb_req,
	input wire ssx_apb_rsp_t apb_rsp,
	input wire logic [2:0] irq_level,
	input wire logic core_halted,
	input wire ssx_exc_t exc_code
);
	logic wr;
	logic go;
	logic hlt;
	logic [15:0] op_reg;
	logic [15:0] ext_reg;
	logic [15:0] sr_reg;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign go = wr && apb_req.paddr == SSX_ADDR_CTRL && apb_req.pwdata[0] && !core_halted;
	assign hlt = go && op_reg == SSX_OP_HALT;
	////////////////////////////////////////
	// Shadow of the instruction and status words
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			op_reg <= 16'h0000;
			ext_reg <= 16'h0000;
			sr_reg <= SSX_SR_RESET;
		end else if (wr && apb_req.paddr == SSX_ADDR_OPCODE) begin
			op_reg <= apb_req.pwdata[15:0];
		end else if (wr && apb_req.paddr == SSX_ADDR_EXT) begin
			ext_reg <= apb_req.pwdata[15:0];
		end else if (wr && apb_req.paddr == SSX_ADDR_STATUS) begin
			sr_reg <= apb_req.pwdata[15:0];
		end else if (hlt && sr_reg[SSX_SR_S]) begin
			sr_reg <= ext_reg;
		end
	end
	////////////////////////////////////////
	a_reset_state: assert property ($rose(rst_n) |-> !core_halted && exc_code == SSX_EXC_RESET)
		else $error("state after reset wrong");
	a_wake_cause: assert property ($fell(core_halted) |-> exc_code inside {SSX_EXC_TRACE, SSX_EXC_IRQ})
		else $error("halt left without trace or interrupt");
	a_halt_hold: assert property (core_halted && $past(core_halted) &&
		irq_level <= sr_reg[SSX_SR_MASK_LO +: 3] |=> core_halted)
		else $error("halt left on masked request");
	a_irq_wake: assert property (core_halted && $past(core_halted) &&
		irq_level > sr_reg[SSX_SR_MASK_LO +: 3] |-> ##[1:2] (!core_halted && exc_code == SSX_EXC_IRQ))
		else $error("interrupt did not end halt");
	a_user_trap: assert property (hlt && !sr_reg[SSX_SR_S] |-> ##2 exc_code == SSX_EXC_PRIV && !core_halted)
		else $error("user halt did not trap");
	a_halt_enter: assert property (hlt && sr_reg[SSX_SR_S] |-> ##2 core_halted)
		else $error("supervisor halt not entered");
	a_trace_exit: assert property (hlt && sr_reg[SSX_SR_S] && sr_reg[SSX_SR_T0] && !sr_reg[SSX_SR_T1]
		|-> ##2 core_halted ##1 (!core_halted && exc_code == SSX_EXC_TRACE))
		else $error("trace exception missing");
	a_no_halt: assert property (go && op_reg != SSX_OP_HALT |-> ##2 !core_halted)
		else $error("halt by other instruction");
	a_err_access: assert property (apb_req.psel && apb_req.penable |->
		apb_rsp.pslverr == (apb_req.paddr > SSX_ADDR_PC || apb_req.paddr[1:0] != 2'h0))
		else $error("slave error does not match address map");
	c_halt: cover property ($rose(core_halted));
	c_irq: cover property ($fell(core_halted) && exc_code == SSX_EXC_IRQ);
	c_trace: cover property ($fell(core_halted) && exc_code == SSX_EXC_TRACE);
endmodule
bind ssx_exec ssx_exec_props chk_u (.mclk(mclk), .rst_n(rst_n), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .irq_level(irq_level), .core_halted(core_halted), .exc_code(exc_code));
`default_nettype wire

/* File: dv/ssx_irq_src.sv */
// Interrupt requester that holds its level until serviced
`timescale 1ns/1ps
`default_nettype none
module ssx_irq_src
	import ssx_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [2:0] want,
	input wire ssx_exc_t exc_code,
	output logic [2:0] irq_level
);
	always_ff @(posedge mclk) begin
		if (!rst_n || exc_code == SSX_EXC_IRQ)
			irq_level <= 3'h0;
		else if (want != 3'h0)
			irq_level <= want;
	end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for the execution block
`timescale 1ns/1ps
`default_nettype none
module tb
	import ssx_pkg::*;
;
	localparam ssx_exc_t ok_e = SSX_EXC_NONE;
	localparam ssx_exc_t bad_e = SSX_EXC_ILLEGAL;
	logic mclk;
	logic rst_n;
	ssx_apb_req_t req;
	ssx_apb_rsp_t rsp;
	logic [2:0] want;
	logic [2:0] irq;
	logic halted;
	ssx_exc_t exc;
	logic [31:0] rd;
	logic err;
	int n_mismatch;
	int total_checks;
	logic [5:0] ea_tab [11] = '{6'h00, 6'h08, 6'h10, 6'h18, 6'h20, 6'h28, 6'h30, 6'h38, 6'h39,
		6'h3a, 6'h3c};
	logic [10:0] ea_ok = 11'h1fd;
	ssx_exec dut_u (.mclk(mclk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp), .irq_level(irq),
		.core_halted(halted), .exc_code(exc));
	ssx_irq_src irq_u (.mclk(mclk), .rst_n(rst_n), .want(want), .exc_code(exc), .irq_level(irq));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	////////////////////////////////////////
	task automatic complete_run();
		if (n_mismatch == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge mclk);
		req.penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		if (rsp.pready !== 1'b1) begin
			n_mismatch++;
			complete_run();
		end
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic run(input logic [15:0] op, input logic [15:0] sr, input logic [31:0] src,
		input logic [31:0] dst, input logic [15:0] ext);
		xfer(1'b1, SSX_ADDR_OPCODE, {16'h0, op});
		xfer(1'b1, SSX_ADDR_EXT, {16'h0, ext});
		xfer(1'b1, SSX_ADDR_SRC, src);
		xfer(1'b1, SSX_ADDR_DST, dst);
		xfer(1'b1, SSX_ADDR_STATUS, {16'h0, sr});
		xfer(1'b1, SSX_ADDR_CTRL, 32'h1);
	endtask
	task automatic opc(input logic [15:0] op, input logic [15:0] sr, input logic [31:0] src,
		input logic [31:0] dst, input logic [31:0] res, input logic [15:0] srx,
		input logic [15:0] msk, input ssx_exc_t ex);
		run(op, sr, src, dst, 16'h0);
		xfer(1'b0, SSX_ADDR_STATUS, 32'h0);
		chk("status", rd & {16'h0, msk}, {16'h0, srx});
		chk("exc", 32'(exc), 32'(ex));
		xfer(1'b0, SSX_ADDR_RESULT, 32'h0);
		if (ex == SSX_EXC_NONE)
			chk("result", rd, res);
	endtask
	function automatic logic cond(input logic [3:0] c, input logic [3:0] f);
		logic [15:0] t;
		logic x;
		x = f[3] ^ f[1];
		t = {f[2] | x, ~f[2] & ~x, x, ~x, f[3], ~f[3], f[1], ~f[1], f[2], ~f[2], f[0], ~f[0],
			f[0] | f[2], ~f[0] & ~f[2], 1'b0, 1'b1};
		return t[c];
	endfunction
	////////////////////////////////////////
	initial begin
		int n;
		logic [3:0] fl;
		rst_n = 1'b0;
		req = '0;
		want = 3'h0;
		n_mismatch = 0;
		total_checks = 0;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		xfer(1'b0, SSX_ADDR_STATUS, 32'h0);
		chk("status", rd, {16'h0, SSX_SR_RESET});
		chk("exc", 32'(exc), 32'(SSX_EXC_RESET));
		xfer(1'b0, 8'h24, 32'h0);
		chk("slverr", 32'(err), 32'h1);
		chk("rdata", rd, 32'h0);
		opc(16'h8302, 16'h2714, 32'h15, 32'h4242, 32'h4226, 16'h2700, 16'hfff5, ok_e);
		opc(16'h870c, 16'h2704, 32'h01, 32'h00, 32'h99, 16'h2711, 16'hfff5, ok_e);
		xfer(1'b0, SSX_ADDR_INFO, 32'h0);
		chk("info", rd & 32'h7f0, 32'h470);
		opc(16'h8302, 16'h2704, 32'h25, 32'h25, 32'h00, 16'h2704, 16'hfff5, ok_e);
		opc(16'h8302, 16'h2711, 32'h24, 32'h25, 32'h00, 16'h2700, 16'hfff5, ok_e);
		opc(16'hd200, 16'h2700, 32'h1, 32'h12345680, 32'h1234567f, 16'h2702, 16'hffff, ok_e);
		opc(16'hd240, 16'h2700, 32'h2, 32'h1, 32'hffff, 16'h2719, 16'hffff, ok_e);
		opc(16'hd280, 16'h271f, 32'h5, 32'h5, 32'h0, 16'h2704, 16'hffff, ok_e);
		opc(16'hd393, 16'h2700, 32'h1, 32'h80000000, 32'h7fffffff, 16'h2702, 16'hffff, ok_e);
		xfer(1'b0, SSX_ADDR_INFO, 32'h0);
		chk("info", rd & 32'h3800, 32'h2800);
		opc(16'hd300, 16'h2700, 32'h1, 32'h5, 32'h0, 16'h2700, 16'hffff, bad_e);
		opc(16'hd208, 16'h2700, 32'h1, 32'h5, 32'h0, 16'h2700, 16'hffff, bad_e);
		opc(16'hd37c, 16'h2700, 32'h1, 32'h5, 32'h0, 16'h2700, 16'hffff, bad_e);
		for (int f = 0; f < 4; f++) begin
			for (int c = 0; c < 16; c++) begin
				fl = 4'(f * 3);
				opc({4'h5, 4'(c), 8'hc0}, {12'h270, fl}, 32'h0, 32'h11,
					{24'h0, {8{cond(4'(c), fl)}}}, {12'h270, fl}, 16'hffff, ok_e);
			end
		end
		for (int i = 0; i < 11; i++) begin
			opc({10'h143, ea_tab[i]}, 16'h2700, 32'h0, 32'h11, 32'hff, 16'h2700, 16'hffff,
				ea_ok[i] ? ok_e : bad_e);
		end
		xfer(1'b1, SSX_ADDR_PC, 32'h100);
		run(SSX_OP_HALT, 16'h0700, 32'h0, 32'h0, 16'h2000);
		xfer(1'b0, SSX_ADDR_STATUS, 32'h0);
		chk("status", rd, 32'h0700);
		chk("exc", 32'(exc), 32'(SSX_EXC_PRIV));
		chk("halt", 32'(halted), 32'h0);
		run(SSX_OP_HALT, 16'h2700, 32'h0, 32'h0, 16'h2300);
		xfer(1'b0, SSX_ADDR_PC, 32'h0);
		chk("pc", rd, 32'h100 + SSX_PC_STEP_HALT);
		xfer(1'b0, SSX_ADDR_STATUS, 32'h0);
		chk("status", rd, 32'h2300);
		want <= 3'h2;
		@(posedge mclk);
		want <= 3'h0;
		repeat (4) @(posedge mclk);
		chk("halt", 32'(halted), 32'h1);
		want <= 3'h5;
		@(posedge mclk);
		want <= 3'h0;
		n = 0;
		while (halted === 1'b1 && n < 10) begin
			@(posedge mclk);
			n++;
		end
		if (halted === 1'b1) begin
			n_mismatch++;
			complete_run();
		end
		@(posedge mclk);
		chk("halt", 32'(halted), 32'h0);
		chk("exc", 32'(exc), 32'(SSX_EXC_IRQ));
		run(SSX_OP_HALT, 16'h6700, 32'h0, 32'h0, 16'h2700);
		repeat (2) @(posedge mclk);
		chk("halt", 32'(halted), 32'h0);
		chk("exc", 32'(exc), 32'(SSX_EXC_TRACE));
		run(SSX_OP_HALT, 16'h2700, 32'h0, 32'h0, 16'h2700);
		xfer(1'b0, SSX_ADDR_PC, 32'h0);
		chk("halt", 32'(halted), 32'h1);
		rst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		chk("halt", 32'(halted), 32'h0);
		chk("exc", 32'(exc), 32'(SSX_EXC_RESET));
		complete_run();
	end
	initial begin
		#5000000;
		n_mismatch++;
		complete_run();
	end
endmodule
`default_nettype wire
